// ---- logic/phy_link_iface_power_ctrl.sv ----
`include "phy_link_map.svh"

module phy_link_iface_power_ctrl #(
  parameter int unsigned CLK_ACT_LP_CYC = `CLK_ACT_LP_CYC
) (
  // reference clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  // interface clock, free running at its source
  input  wire logic       iface_clk_in,
  // power management
  input  wire logic       link_power_status_in,
  input  wire logic       ports_active_in,
  output logic            low_power_out,
  output logic            iface_clk_gate_out,
  // pins toward the link
  input  wire logic [1:0] interface_control_pair_in,
  output logic      [1:0] interface_control_pair_out,
  output logic            ctl_oe_n_out,
  output logic      [7:0] data_out,
  output logic            data_oe_n_out,
  input  wire logic       link_request_line_in,
  // core side, on the interface clock
  input  wire logic [1:0] core_ctl_in,
  input  wire logic [7:0] core_data_in,
  input  wire logic       tx_grant_req_in,
  output logic            link_request_out,
  output logic            req_accept_out,
  output logic            pending_flush_out,
  output logic            link_owns_out
);

  // ----------------------------------------------------------------
  // power-status timers on the reference clock
  // ----------------------------------------------------------------
  logic                         lps_m_r, lps_s_r;
  logic [9:0]                   lo_cnt_r, lo_cnt_nxt;
  logic [17:0]                  wake_cnt_r, wake_cnt_nxt;
  phy_link_pkg::iface_mode_t    mode_r, mode_nxt;
  logic                         low_power_r, clk_run_r, iface_rst_r;
  logic                         wake_done;

  // any high sample restarts the count, so short pulses read as asserted
  assign lo_cnt_nxt = lps_s_r ? 10'h000 :
                      (lo_cnt_r == 10'(`DISABLE_RECOG_CYC)) ? lo_cnt_r : lo_cnt_r + 10'h001;
  assign wake_done  = (wake_cnt_r >= 18'(CLK_ACT_LP_CYC));

  always_comb begin
    mode_nxt     = mode_r;
    wake_cnt_nxt = 18'h00000;
    case (mode_r)
      phy_link_pkg::M_OPER: begin
        if (lo_cnt_r == 10'(`RESET_RECOG_CYC)) begin
          mode_nxt = phy_link_pkg::M_RESET;
        end
      end
      phy_link_pkg::M_RESET: begin
        if (lps_s_r) begin
          mode_nxt = phy_link_pkg::M_OPER;
        end else if (lo_cnt_r == 10'(`DISABLE_RECOG_CYC)) begin
          mode_nxt = phy_link_pkg::M_DISABLED;
        end
      end
      phy_link_pkg::M_DISABLED: begin
        // the wake count only runs once low power has been entered
        if (lps_s_r && (!low_power_r || wake_done)) begin
          mode_nxt = phy_link_pkg::M_OPER;
        end else if (lps_s_r) begin
          wake_cnt_nxt = wake_cnt_r + 18'h00001;
        end
      end
      default: mode_nxt = phy_link_pkg::M_DISABLED;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    lps_m_r <= link_power_status_in;
    lps_s_r <= lps_m_r;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      mode_r      <= phy_link_pkg::M_DISABLED;
      lo_cnt_r    <= 10'(`DISABLE_RECOG_CYC);
      wake_cnt_r  <= 18'h00000;
      low_power_r <= 1'b0;
      clk_run_r   <= 1'b0;
      iface_rst_r <= 1'b1;
    end else begin
      mode_r      <= mode_nxt;
      lo_cnt_r    <= lo_cnt_nxt;
      wake_cnt_r  <= wake_cnt_nxt;
      low_power_r <= (mode_nxt == phy_link_pkg::M_DISABLED) &&
                     (low_power_r || !ports_active_in);
      clk_run_r   <= (mode_nxt != phy_link_pkg::M_DISABLED);
      iface_rst_r <= (mode_nxt != phy_link_pkg::M_OPER);
    end
  end

  assign low_power_out = low_power_r;

  // ----------------------------------------------------------------
  // crossings into the interface clock domain
  // ----------------------------------------------------------------
  logic rst_m_r, rst_s_r, run_m_r, run_s_r, irst_m_r, irst_s_r;
  logic [1:0] ctl_m_r, ctl_s_r;
  logic       req_m_r, req_s_r;

  always_ff @(posedge iface_clk_in) begin
    rst_m_r  <= rst_n_in;
    rst_s_r  <= rst_m_r;
    run_m_r  <= clk_run_r;
    run_s_r  <= run_m_r;
    irst_m_r <= iface_rst_r;
    irst_s_r <= irst_m_r;
    ctl_m_r  <= interface_control_pair_in;
    ctl_s_r  <= ctl_m_r;
    req_m_r  <= link_request_line_in;
    req_s_r  <= req_m_r;
  end

  // ----------------------------------------------------------------
  // pin sequencing on the interface clock
  // ----------------------------------------------------------------
  phy_link_pkg::link_state_t lst_r, lst_nxt;
  logic [2:0] init_cnt_r, init_cnt_nxt;
  logic [1:0] idle_run_r, idle_run_nxt;
  logic       seen_act_r, seen_act_nxt;
  logic [5:0] hold_cnt_r, hold_cnt_nxt;
  logic [1:0] link_age_r, link_age_nxt;
  logic       link_live;
  logic       link_idle, link_done, oper_nxt, oper_now;
  logic [1:0] ctl_nxt;
  logic [7:0] data_nxt;
  logic       drive_nxt;

  assign link_idle = (ctl_s_r == `CTL_IDLE);
  // two idles after activity, or three idles when the link never left idle
  // first two owned cycles still show our own grant and idle through the synchroniser
  assign link_age_nxt = (lst_r != phy_link_pkg::L_LINK) ? 2'h0 :
                        (link_age_r == 2'h2) ? link_age_r : link_age_r + 2'h1;
  assign link_live = (lst_r == phy_link_pkg::L_LINK) && (link_age_r == 2'h2);
  assign link_done = link_live && link_idle && ((seen_act_r && idle_run_r == 2'h1) ||
                                   (idle_run_r == 2'h2) ||
                                   (hold_cnt_r == 6'(`LINK_HOLD_MAX_CYC)));
  assign oper_now  = (lst_r == phy_link_pkg::L_IDLE) || (lst_r == phy_link_pkg::L_OWN) ||
                     (lst_r == phy_link_pkg::L_GRANT) || (lst_r == phy_link_pkg::L_HAND) ||
                     (lst_r == phy_link_pkg::L_LINK);
  assign oper_nxt  = (lst_nxt == phy_link_pkg::L_IDLE) || (lst_nxt == phy_link_pkg::L_OWN) ||
                     (lst_nxt == phy_link_pkg::L_GRANT) || (lst_nxt == phy_link_pkg::L_HAND) ||
                     (lst_nxt == phy_link_pkg::L_LINK);

  always_comb begin
    lst_nxt      = lst_r;
    init_cnt_nxt = 3'h0;
    case (lst_r)
      phy_link_pkg::L_QUIET: begin
        if (!irst_s_r && run_s_r) begin
          lst_nxt = phy_link_pkg::L_INIT;
        end
      end
      phy_link_pkg::L_INIT: begin
        init_cnt_nxt = init_cnt_r + 3'h1;
        if (init_cnt_r == 3'(`INIT_LOW_CYC - 1)) begin
          lst_nxt = phy_link_pkg::L_RXON;
        end
      end
      phy_link_pkg::L_RXON:  lst_nxt = phy_link_pkg::L_IDLE;
      phy_link_pkg::L_IDLE:  lst_nxt = phy_link_pkg::L_OWN;
      phy_link_pkg::L_OWN: begin
        if (tx_grant_req_in) begin
          lst_nxt = phy_link_pkg::L_GRANT;
        end
      end
      phy_link_pkg::L_GRANT: lst_nxt = phy_link_pkg::L_HAND;
      phy_link_pkg::L_HAND:  lst_nxt = phy_link_pkg::L_LINK;
      phy_link_pkg::L_LINK: begin
        if (link_done) begin
          lst_nxt = phy_link_pkg::L_IDLE;
        end
      end
      default: lst_nxt = phy_link_pkg::L_QUIET;
    endcase
    if (irst_s_r || !run_s_r) begin
      lst_nxt = phy_link_pkg::L_QUIET;
    end
  end

  // link-owned tracking: restarted whenever the link takes the pins
  assign idle_run_nxt = !link_live ? 2'h0 :
                        !link_idle ? 2'h0 :
                        (idle_run_r == 2'h3) ? idle_run_r : idle_run_r + 2'h1;
  assign seen_act_nxt = link_live && (seen_act_r || !link_idle);
  assign hold_cnt_nxt = !link_live ? 6'h00 :
                        (ctl_s_r == `CTL_LINK_HOLD &&
                         hold_cnt_r != 6'(`LINK_HOLD_MAX_CYC)) ? hold_cnt_r + 6'h01 :
                        hold_cnt_r;

  // outputs follow the next state so pins and state stay aligned
  assign ctl_nxt   = (lst_nxt == phy_link_pkg::L_RXON)  ? `CTL_RECEIVE :
                     (lst_nxt == phy_link_pkg::L_GRANT) ? `CTL_GRANT :
                     (lst_nxt == phy_link_pkg::L_OWN)   ? core_ctl_in : `CTL_IDLE;
  assign data_nxt  = (lst_nxt == phy_link_pkg::L_RXON)  ? `DATA_ON_CODE :
                     (lst_nxt == phy_link_pkg::L_OWN)   ? core_data_in : `DATA_ZERO;
  assign drive_nxt = (lst_nxt != phy_link_pkg::L_LINK);

  always_ff @(posedge iface_clk_in) begin
    if (!rst_s_r) begin
      lst_r                      <= phy_link_pkg::L_QUIET;
      init_cnt_r                 <= 3'h0;
      idle_run_r                 <= 2'h0;
      seen_act_r                 <= 1'b0;
      hold_cnt_r                 <= 6'h00;
      link_age_r                 <= 2'h0;
      interface_control_pair_out <= `CTL_IDLE;
      data_out                   <= `DATA_ZERO;
      ctl_oe_n_out               <= 1'b0;
      data_oe_n_out              <= 1'b0;
      iface_clk_gate_out         <= 1'b0;
      link_request_out           <= 1'b0;
      req_accept_out             <= 1'b0;
      pending_flush_out          <= 1'b0;
      link_owns_out              <= 1'b0;
    end else begin
      lst_r                      <= lst_nxt;
      init_cnt_r                 <= init_cnt_nxt;
      idle_run_r                 <= idle_run_nxt;
      seen_act_r                 <= seen_act_nxt;
      hold_cnt_r                 <= hold_cnt_nxt;
      link_age_r                 <= link_age_nxt;
      interface_control_pair_out <= ctl_nxt;
      data_out                   <= data_nxt;
      ctl_oe_n_out               <= !drive_nxt;
      data_oe_n_out              <= !drive_nxt;
      iface_clk_gate_out         <= run_s_r;
      link_request_out           <= req_s_r && oper_nxt;
      req_accept_out             <= oper_nxt;
      pending_flush_out          <= oper_now && !oper_nxt;
      link_owns_out              <= !drive_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks on the reference clock
  // ----------------------------------------------------------------
  property p_reset_recog;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (mode_r == phy_link_pkg::M_OPER && lo_cnt_r == 10'(`RESET_RECOG_CYC))
      |=> (mode_r == phy_link_pkg::M_RESET) && iface_rst_r;
  endproperty
  a_reset_recog: assert property (p_reset_recog) else $error("reset not recognised");

  property p_disable_recog;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (mode_r == phy_link_pkg::M_RESET && !lps_s_r && lo_cnt_r == 10'(`DISABLE_RECOG_CYC))
      |=> (mode_r == phy_link_pkg::M_DISABLED) && !clk_run_r;
  endproperty
  a_disable_recog: assert property (p_disable_recog) else $error("disable missed");

  property p_pulse_filter;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      lps_s_r |=> (lo_cnt_r == 10'h000) ##1 (mode_r != phy_link_pkg::M_RESET || !$past(lps_s_r, 2));
  endproperty
  a_pulse_filter: assert property (p_pulse_filter) else $error("timer not restarted");

  property p_hw_reset;
    @(posedge ref_clk_in) !rst_n_in |=> (mode_r == phy_link_pkg::M_DISABLED) && !clk_run_r;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("hardware reset not disabled");

  property p_low_power;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (mode_r == phy_link_pkg::M_DISABLED && !lps_s_r && !ports_active_in) |=> low_power_out;
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power not entered");

  property p_fast_wake;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (mode_r == phy_link_pkg::M_DISABLED && lps_s_r && !low_power_r) |=> clk_run_r;
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("clock not restarted");

  // ----------------------------------------------------------------
  // checks on the interface clock, then cover points on both clocks
  // ----------------------------------------------------------------
  property p_quiet_pins;
    @(posedge iface_clk_in) disable iff (!rst_s_r)
      (lst_r == phy_link_pkg::L_QUIET || lst_r == phy_link_pkg::L_INIT)
      |-> interface_control_pair_out == `CTL_IDLE && data_out == `DATA_ZERO &&
          !ctl_oe_n_out && !link_request_out;
  endproperty
  a_quiet_pins: assert property (p_quiet_pins) else $error("pins not low");

  property p_init_seq;
    @(posedge iface_clk_in) disable iff (!rst_s_r)
      $rose(lst_r == phy_link_pkg::L_INIT) |-> (lst_r == phy_link_pkg::L_INIT) [*7]
      ##1 (interface_control_pair_out == `CTL_RECEIVE && data_out == `DATA_ON_CODE)
      ##1 (interface_control_pair_out == `CTL_IDLE && data_out == `DATA_ZERO);
  endproperty
  a_init_seq: assert property (p_init_seq) else $error("bad init sequence");

  property p_grant_seq;
    @(posedge iface_clk_in) disable iff (!rst_s_r || irst_s_r || !run_s_r)
      (lst_r == phy_link_pkg::L_GRANT) |-> interface_control_pair_out == `CTL_GRANT
      ##1 (interface_control_pair_out == `CTL_IDLE && !ctl_oe_n_out) ##1 ctl_oe_n_out;
  endproperty
  a_grant_seq: assert property (p_grant_seq) else $error("bad grant handover");

  property p_idle_after;
    @(posedge iface_clk_in) disable iff (!rst_s_r)
      (lst_r == phy_link_pkg::L_LINK) ##1 ctl_oe_n_out == 1'b0
      |-> interface_control_pair_out == `CTL_IDLE;
  endproperty
  a_idle_after: assert property (p_idle_after) else $error("no idle after release");

  property p_flush;
    @(posedge iface_clk_in) disable iff (!rst_s_r)
      $fell(req_accept_out) |-> pending_flush_out && !link_request_out;
  endproperty
  a_flush: assert property (p_flush) else $error("pending work not flushed");

  c_reset_restore: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    mode_r == phy_link_pkg::M_RESET ##1 mode_r == phy_link_pkg::M_OPER);
  c_low_power_wake: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    low_power_r ##1 mode_r == phy_link_pkg::M_OPER);
  c_cancel: cover property (@(posedge iface_clk_in) disable iff (!rst_s_r)
    lst_r == phy_link_pkg::L_LINK && !seen_act_r ##1 lst_r == phy_link_pkg::L_IDLE);
  c_init_done: cover property (@(posedge iface_clk_in) disable iff (!rst_s_r)
    lst_r == phy_link_pkg::L_RXON ##1 lst_r == phy_link_pkg::L_IDLE);

endmodule

// ---- logic/phy_link_map.svh ----
`ifndef PHY_LINK_MAP_SVH
`define PHY_LINK_MAP_SVH

// ----------------------------------------------------------------
// clock and synchroniser latency
// ----------------------------------------------------------------
`define REF_CLK_PERIOD_NS      50
`define SYNC_LATENCY_CYC       2

// ----------------------------------------------------------------
// power-status recognition windows, in ns
// ----------------------------------------------------------------
`define RESET_RECOG_MIN_NS     2600
`define RESET_RECOG_MAX_NS     2680
`define DISABLE_RECOG_MIN_NS   26030
`define DISABLE_RECOG_MAX_NS   26110
`define PULSED_LOW_MAX_NS      2600
`define PULSED_HIGH_MIN_NS     21
`define CLK_ACT_LP_MIN_NS      5300000
`define CLK_ACT_LP_MAX_NS      7300000

// ceiling of the least time, less the synchroniser delay for the two recognition counts
`define RESET_RECOG_CYC   ((`RESET_RECOG_MIN_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS - `SYNC_LATENCY_CYC)
`define DISABLE_RECOG_CYC ((`DISABLE_RECOG_MIN_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS - `SYNC_LATENCY_CYC)
`define CLK_ACT_LP_CYC    ((`CLK_ACT_LP_MIN_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// interface sequencing counts
// ----------------------------------------------------------------
`define INIT_LOW_CYC           7
`define LINK_HOLD_MAX_CYC      47

// ----------------------------------------------------------------
// control pair codes and data values
// ----------------------------------------------------------------
`define CTL_IDLE               2'h0
`define CTL_STATUS             2'h1
`define CTL_RECEIVE            2'h2
`define CTL_GRANT              2'h3
`define CTL_LINK_HOLD          2'h1
`define CTL_LINK_TRANSMIT      2'h2
`define DATA_ON_CODE           8'hFF
`define DATA_ZERO              8'h00

`endif

// ---- logic/phy_link_pkg.sv ----
package phy_link_pkg;

  // ----------------------------------------------------------------
  // interface condition seen from the power-status timers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    M_OPER,
    M_RESET,
    M_DISABLED
  } iface_mode_t;

  // ----------------------------------------------------------------
  // sequencing of the pins on the interface clock
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    L_QUIET,
    L_INIT,
    L_RXON,
    L_IDLE,
    L_OWN,
    L_GRANT,
    L_HAND,
    L_LINK
  } link_state_t;

endpackage

// ---- tb/link_side_model.sv ----
module link_side_model (
  // interface clock in, then pins driven toward the phy
  input  wire logic       iface_clk_in,
  output logic            lps_out,
  output logic      [1:0] ctl_out,
  output logic            ctl_en_out,
  output logic            req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    lps_out = 1'b0;
    ctl_out = 2'h0;
    ctl_en_out = 1'b0;
    req_out = 1'b0;
  end
  // dropping power-status quiets the pins at once, well inside the allowed time
  task automatic set_lps(input logic v);
    lps_out = v;
    if (!v) begin
      ctl_en_out = 1'b0;
      req_out = 1'b0;
    end
  endtask
  task automatic set_req(input logic v);
    req_out = v;
  endtask
  task automatic pulse_lps(input int lo, input int hi, input int n);
    repeat (n) begin
      lps_out = 1'b0;
      #(lo);
      lps_out = 1'b1;
      #(hi);
    end
  endtask
  // cancelled transmit: optional idle, holds, then idles and release
  task automatic cancel(input int lead, input int holds);
    ctl_en_out = 1'b1;
    for (int i = -lead; i < holds; i++) begin
      ctl_out = (i < 0) ? 2'h0 : 2'h1;
      @(negedge iface_clk_in);
    end
    ctl_out = 2'h0;
    repeat (2) @(negedge iface_clk_in);
    ctl_en_out = 1'b0;
  endtask
endmodule

// ---- tb/test_phy_link_iface_power_ctrl.sv ----
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", nm, (e), (g)); end end
module test_phy_link_iface_power_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk, iface_clk, rst_n, ports_active, tx_grant, link_power_status, link_en, link_request_line;
  logic       low_power, gate, ctl_oe_n, accept, flush, owns, link_request_line_out, data_oe_n;
  logic [1:0] core_ctl, ctl_out, link_ctl, last_ctl;
  logic [7:0] core_data, data_out;
  wire  [1:0] ctl_wire;
  int         n_errors, checks_done, cyc, flushes, f0, seed, i, n, v;
  int         leads[3] = '{1, 1, 0};
  int         holds[3] = '{0, 1, 47};
  // released pair floats: show a changing pattern, never the last value
  assign ctl_wire = !ctl_oe_n ? ctl_out : (link_en ? link_ctl : ~last_ctl);
  always #25 ref_clk = ~ref_clk;
  always #80 iface_clk = ~iface_clk;
  always @(posedge iface_clk) begin
    last_ctl <= ctl_wire;
    if (flush === 1'b1) flushes <= flushes + 1;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  phy_link_iface_power_ctrl #(.CLK_ACT_LP_CYC(20)) dut (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n), .iface_clk_in(iface_clk),
    .link_power_status_in(link_power_status), .ports_active_in(ports_active), .low_power_out(low_power),
    .iface_clk_gate_out(gate), .interface_control_pair_in(ctl_wire),
    .interface_control_pair_out(ctl_out), .ctl_oe_n_out(ctl_oe_n), .data_out(data_out),
    .data_oe_n_out(data_oe_n), .link_request_line_in(link_request_line), .core_ctl_in(core_ctl),
    .core_data_in(core_data), .tx_grant_req_in(tx_grant), .link_request_out(link_request_line_out),
    .req_accept_out(accept), .pending_flush_out(flush), .link_owns_out(owns));
  link_side_model lnk (.iface_clk_in(iface_clk), .lps_out(link_power_status), .ctl_out(link_ctl),
    .ctl_en_out(link_en), .req_out(link_request_line));
  task automatic finish_test();
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic restart(input bit from_lp);
    lnk.set_lps(1'b1);
    if (from_lp) begin
      repeat (15) @(negedge ref_clk);
      `CHK("gate_lp", 1'b0, gate)
    end
    for (i = 0; i < 80 && gate !== 1'b1; i++) @(negedge iface_clk);
    `CHK("gate", 1'b1, gate)
    n = 0;
    for (i = 0; i < 40 && ctl_out !== 2'h2; i++) begin
      n += ({ctl_out, data_out} === 10'h000);
      `CHK("accept_init", 1'b0, accept)
      @(negedge iface_clk);
    end
    `CHK("init_low", 1'b1, n >= 7)
    `CHK("rx_on", 8'hFF, data_out)
    @(negedge iface_clk);
    `CHK("init_idle", 10'h000, {ctl_out, data_out})
    repeat (3) @(negedge iface_clk);
    `CHK("accept", 1'b1, accept)
  endtask
  task automatic passthru(input int cnt);
    repeat (cnt) begin
      v = $random(seed);
      core_ctl = (v[1:0] == 2'h3) ? 2'h1 : v[1:0];
      core_data = v[15:8];
      ports_active = v[16];
      lnk.set_req(v[20]);
      repeat (3) @(negedge iface_clk);
      `CHK("pass", {core_ctl, core_data}, {ctl_out, data_out})
      `CHK("link_request_line", v[20], link_request_line_out)
    end
    lnk.set_req(1'b0);
    core_ctl = 2'h0;
    core_data = 8'h00;
  endtask
  task automatic grant_cancel(input int lead, input int hold_cnt);
    repeat (2) @(negedge iface_clk);
    tx_grant = 1'b1;
    @(negedge iface_clk);
    tx_grant = 1'b0;
    `CHK("grant", 2'h3, ctl_out)
    @(negedge iface_clk);
    `CHK("hand", 3'h0, {ctl_out, ctl_oe_n})
    @(negedge iface_clk);
    `CHK("release", 3'h7, {ctl_oe_n, data_oe_n, owns})
    // status waiting in the core must not reach the pins before an idle
    core_ctl = 2'h1;
    lnk.cancel(lead, hold_cnt);
    for (i = 0; i < 10 && ctl_oe_n !== 1'b0; i++) @(negedge iface_clk);
    `CHK("regain", 4'h0, {ctl_oe_n, owns, ctl_out})
    core_ctl = 2'h0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    iface_clk = 1'b0;
    rst_n = 1'b0;
    ports_active = 1'b0;
    tx_grant = 1'b0;
    core_ctl = 2'h0;
    core_data = 8'h00;
    last_ctl = 2'h0;
    seed = 35515;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge iface_clk);
    `CHK("hw_reset", 13'h0000, {gate, accept, ctl_oe_n, ctl_out, data_out})
    `CHK("low_power", 1'b1, low_power)
    restart(1'b1);
    passthru(6);
    for (int k = 0; k < 3; k++) grant_cancel(leads[k], holds[k]);
    passthru(4);
    lnk.set_req(1'b1);
    f0 = flushes;
    lnk.pulse_lps(1500, 500, 6);
    lnk.pulse_lps(2400, 700, 4);
    `CHK("pulsed", 3'h7, {accept, link_request_line_out, flushes == f0})
    lnk.set_lps(1'b0);
    #2547;
    `CHK("before_reset", 1'b1, accept)
    #800;
    `CHK("reset", 14'h1001, {accept, gate, ctl_oe_n, ctl_out, data_out, flushes == f0 + 1})
    // a misbehaving request during reset must be dropped
    lnk.set_req(1'b1);
    #1003;
    `CHK("req_ignored", 1'b0, link_request_line_out)
    lnk.set_req(1'b0);
    #11003;
    restart(1'b0);
    passthru(2);
    @(negedge ref_clk);
    ports_active = 1'b1;
    lnk.set_lps(1'b0);
    #25903;
    `CHK("before_disable", 1'b1, gate)
    #703;
    `CHK("disabled", 2'h0, {gate, low_power})
    `CHK("disabled_pins", 10'h000, {ctl_out, data_out})
    restart(1'b0);
    passthru(4);
    finish_test();
  end
endmodule
